/* File: rtl/uifc_regs.vh */
`ifndef UIFC_REGS_VH
`define UIFC_REGS_VH
// Register offsets on the plain register port
`define UIFC_OFF_RXHOLD   3'h0
`define UIFC_OFF_MASK     3'h1
`define UIFC_OFF_STATUS   3'h2
`define UIFC_OFF_QCTRL    3'h2
`define UIFC_OFF_FORMAT   3'h3
`define UIFC_OFF_LINE     3'h5
`define UIFC_OFF_MODEM    3'h6
`define UIFC_OFF_ENH      3'h7
// Reset values
`define UIFC_RST_STATUS   8'h01
`define UIFC_RST_FORMAT   8'h00
`define UIFC_RST_MASK     8'h00
`define UIFC_RST_QCTRL    8'h00
`define UIFC_RST_ENH      8'h00
// Status codes, bits 5..0
`define UIFC_CODE_LINE    6'h06
`define UIFC_CODE_TOUT    6'h0C
`define UIFC_CODE_RECEIVE_READY_PIN   6'h04
`define UIFC_CODE_TRANSMIT_READY_PIN   6'h02
`define UIFC_CODE_MODEM   6'h00
`define UIFC_CODE_XOFF    6'h10
`define UIFC_CODE_FLOW    6'h20
`define UIFC_CODE_NONE    6'h01
// Queue control field positions, then the enable bit of the enhanced register
`define UIFC_QC_EN        0
`define UIFC_QC_RXRST     1
`define UIFC_QC_TXRST     2
`define UIFC_QC_DMA       3
`define UIFC_ENH_BIT      4
// Time-out: 4 characters plus 12 bits, counted in bit times
`define UIFC_TOUT_CHARS   4
`define UIFC_TOUT_BITS    12
`endif

/* File: rtl/uifc_ctrl.v */
// Summary of operation
// - Status read shows only top pending source
// - Line status is level 1, code 000110
// - Timeout, rx ready, tx ready, modem codes
// - Xoff/special 010000, flow edge 100000, idle 000001
// - Line bits 1-4 raise; line read clears
// - Timeout after 4 chars plus 12 bits
// - Rx ready held while fill at trigger
// - Tx ready set; status read or write clears
// - Modem bits 0-3 raise; modem read clears
// - Xoff flag cleared by status read or xon
// - Special flag cleared by read or next char
// - Flow line rising edges; modem read clears
// - Bit 0 low while anything pending
// - Bits 4,5 only with enhanced enable
// - Bits 7:6 mirror queue enable
// - Queue enable gates all other control bits
// - Rx queue reset pulse, self clearing
// - Tx queue reset pulse, self clearing
// - DMA mode changes ready pin behaviour
// - Tx trigger 8/16/32/56, below or empty
// - Rx trigger 8/16/56/60, level at or above
// - Word length 5 to 8, default 5
// - Stop bits 1, 1.5 or 2
// - Mask bits gate each source
`timescale 1ns/10ps
`include "uifc_regs.vh"
module uifc_ctrl #(
    parameter LVL_W = 7
) (
    input  wire             core_clk,
    input  wire             rst_n,
    input  wire [2:0]       reg_addr,
    input  wire [7:0]       reg_wdata,
    input  wire             reg_wr,
    input  wire             reg_rd,
    output reg  [7:0]       reg_rdata,
    input  wire [7:0]       line_status,
    input  wire [7:0]       modem_status,
    input  wire [7:0]       rx_data,
    input  wire [LVL_W-1:0] rx_level,
    input  wire [LVL_W-1:0] tx_level,
    input  wire             rx_char_stb,
    input  wire             bit_tick,
    input  wire             xoff_seen,
    input  wire             xon_seen,
    input  wire             special_seen,
    input  wire             cts_pin,
    input  wire             rts_out,
    output reg              rx_queue_reset,
    output reg              tx_queue_reset,
    output reg              transmit_ready_pin_n,
    output reg              receive_ready_pin_n,
    output reg              queue_enable,
    output reg  [1:0]       word_len_sel,
    output reg  [1:0]       stop_half_bits,
    output reg              irq_pending,
    output reg              thr_write_stb
);
    reg [7:0] mask_q;
    reg [7:0] enh_q;
    reg [7:0] format_q;
    reg       qen_q;
    reg       dma_q;
    reg [1:0] txtrig_q;
    reg [1:0] rxtrig_q;
    reg       tout_q;
    reg       transmit_ready_pin_q;
    reg       xoff_q;
    reg       spec_q;
    reg       flow_q;
    reg       tx_armed_q;
    reg       cts_s1_q;
    reg       cts_s2_q;
    reg       cts_prev_q;
    reg       rts_prev_q;
    reg [7:0] tout_cnt_q;
    reg [LVL_W-1:0] tx_prev_q;

    wire enh = enh_q[`UIFC_ENH_BIT];
    wire rd_modem  = reg_rd && reg_addr == `UIFC_OFF_MODEM;
    wire rd_status = reg_rd && reg_addr == `UIFC_OFF_STATUS;
    wire rd_rxhold = reg_rd && reg_addr == `UIFC_OFF_RXHOLD;
    wire wr_thr    = reg_wr && reg_addr == `UIFC_OFF_RXHOLD && !format_q[7];
    wire wr_qc     = reg_wr && reg_addr == `UIFC_OFF_QCTRL && format_q != 8'hBF;
    wire wr_enh    = reg_wr && reg_addr == `UIFC_OFF_ENH;
    wire wr_mask   = reg_wr && reg_addr == `UIFC_OFF_MASK && !format_q[7];
    wire wr_fmt    = reg_wr && reg_addr == `UIFC_OFF_FORMAT;
    wire qc_en_bit = reg_wdata[`UIFC_QC_EN];

    reg [LVL_W-1:0] rx_trig;
    reg [LVL_W-1:0] tx_trig;
    always @* begin
        case (rxtrig_q)
            2'h0:    rx_trig = 7'd8;
            2'h1:    rx_trig = 7'd16;
            2'h2:    rx_trig = 7'd56;
            default: rx_trig = 7'd60;
        endcase
    end
    always @* begin
        case (enh ? txtrig_q : 2'h0)
            2'h0:    tx_trig = 7'd8;
            2'h1:    tx_trig = 7'd16;
            2'h2:    tx_trig = 7'd32;
            default: tx_trig = 7'd56;
        endcase
    end

    // Line and modem sources are levels of their registers, cleared by their reads
    wire src_line  = mask_q[2] && |line_status[4:1];
    wire src_modem = mask_q[3] && |modem_status[3:0];
    // Non-queue mode: any data counts as reaching the trigger
    wire rx_at = qen_q ? (rx_level >= rx_trig) : (rx_level != 0);
    wire src_rx    = mask_q[0] && rx_at;
    wire src_tout  = mask_q[0] && tout_q;
    wire src_tx    = mask_q[1] && transmit_ready_pin_q;
    wire src_xoff  = enh && mask_q[5] && (xoff_q || spec_q);
    wire src_flow  = enh && flow_q && (mask_q[6] || mask_q[7]);

    reg [5:0] code;
    always @* begin
        // Priority chain; lower ones wait unacknowledged
        if (src_line)
            code = `UIFC_CODE_LINE;
        else if (src_tout)
            code = `UIFC_CODE_TOUT;
        else if (src_rx)
            code = `UIFC_CODE_RECEIVE_READY_PIN;
        else if (src_tx)
            code = `UIFC_CODE_TRANSMIT_READY_PIN;
        else if (src_modem)
            code = `UIFC_CODE_MODEM;
        else if (src_xoff)
            code = `UIFC_CODE_XOFF;
        else if (src_flow)
            code = `UIFC_CODE_FLOW;
        else
            code = `UIFC_CODE_NONE;
    end
    wire [7:0] status_word = {qen_q, qen_q, code};

    // Clears only hit the source shown in this read
    wire ack_tx   = rd_status && code == `UIFC_CODE_TRANSMIT_READY_PIN;
    wire ack_xoff = rd_status && code == `UIFC_CODE_XOFF;

    // Time-out limit in bit times: 4 chars of (start+data+stop) plus 12
    wire [3:0] char_bits = 4'd7 + {2'b00, format_q[1:0]};
    wire [7:0] tout_lim = {2'b00, char_bits, 2'b00} + 8'd12;

    wire cts_rise = cts_s2_q && !cts_prev_q && enh_q[7];
    wire rts_rise = rts_out && !rts_prev_q && enh_q[6];
    wire tx_below = tx_level < tx_trig && tx_prev_q >= tx_trig;
    wire tx_empty = tx_level == 0 && tx_prev_q != 0 && !tx_armed_q;
    wire tx_flush = wr_qc && qc_en_bit && reg_wdata[`UIFC_QC_TXRST];

    // Pin-side history for edge detection; cts_pin is synchronised first
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cts_s1_q   <= 1'b0;
            cts_s2_q   <= 1'b0;
            cts_prev_q <= 1'b0;
            rts_prev_q <= 1'b0;
            tx_prev_q  <= {LVL_W{1'b0}};
        end else begin
            cts_s1_q   <= cts_pin;
            cts_s2_q   <= cts_s1_q;
            cts_prev_q <= cts_s2_q;
            rts_prev_q <= rts_out;
            tx_prev_q  <= tx_level;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            thr_write_stb <= 1'b0;
        end else begin
            thr_write_stb <= wr_thr;
        end
    end

    // Upper mask bits only exist with the enhanced enable
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `UIFC_RST_MASK;
        end else if (wr_mask && enh) begin
            mask_q <= reg_wdata;
        end else if (wr_mask) begin
            mask_q <= {4'h0, reg_wdata[3:0]};
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            format_q <= `UIFC_RST_FORMAT;
        end else if (wr_fmt) begin
            format_q <= reg_wdata;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enh_q <= `UIFC_RST_ENH;
        end else if (wr_enh) begin
            enh_q <= reg_wdata;
        end
    end

    // Queue control: with bit 0 low only the enable is touched
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            qen_q          <= 1'b0;
            dma_q          <= 1'b0;
            txtrig_q       <= 2'h0;
            rxtrig_q       <= 2'h0;
            rx_queue_reset <= 1'b0;
            tx_queue_reset <= 1'b0;
        end else begin
            rx_queue_reset <= 1'b0;
            tx_queue_reset <= 1'b0;
            if (wr_qc) begin
                qen_q <= qc_en_bit;
                if (qc_en_bit) begin
                    rx_queue_reset <= reg_wdata[`UIFC_QC_RXRST];
                    tx_queue_reset <= reg_wdata[`UIFC_QC_TXRST];
                    dma_q          <= reg_wdata[`UIFC_QC_DMA];
                    rxtrig_q       <= reg_wdata[7:6];
                    if (enh)
                        txtrig_q <= reg_wdata[5:4];
                end
            end
        end
    end

    // Time-out timer restarts on every char in or out; runs only with data
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tout_cnt_q <= 8'h00;
        end else if (rx_char_stb || rd_rxhold || rx_level == 0) begin
            tout_cnt_q <= 8'h00;
        end else if (bit_tick && tout_cnt_q != tout_lim) begin
            tout_cnt_q <= tout_cnt_q + 8'h01;
        end
    end

    // Set wins over the holding-register read in the same cycle
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tout_q <= 1'b0;
        end else if (bit_tick && rx_level != 0 && tout_cnt_q == tout_lim - 8'h01) begin
            tout_q <= 1'b1;
        end else if (rd_rxhold) begin
            tout_q <= 1'b0;
        end
    end

    // Refill above trigger disarms the empty event
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_armed_q <= 1'b0;
        end else if (tx_level > tx_trig) begin
            tx_armed_q <= 1'b1;
        end else if (tx_level == 0) begin
            tx_armed_q <= 1'b0;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_ready_pin_q <= 1'b0;
        end else if (tx_below || tx_empty || tx_flush) begin
            transmit_ready_pin_q <= 1'b1;
        end else if (ack_tx || wr_thr) begin
            transmit_ready_pin_q <= 1'b0;
        end
    end

    // A detection in the clearing cycle keeps the flag
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            xoff_q <= 1'b0;
        end else if (xoff_seen) begin
            xoff_q <= 1'b1;
        end else if (ack_xoff || xon_seen) begin
            xoff_q <= 1'b0;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            spec_q <= 1'b0;
        end else if (special_seen) begin
            spec_q <= 1'b1;
        end else if (ack_xoff || rx_char_stb) begin
            spec_q <= 1'b0;
        end
    end

    // Only the modem register read clears flow edges, never a status read
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flow_q <= 1'b0;
        end else if (cts_rise || rts_rise) begin
            flow_q <= 1'b1;
        end else if (rd_modem) begin
            flow_q <= 1'b0;
        end
    end

    reg [7:0] rd_mux;
    always @* begin
        case (reg_addr)
            `UIFC_OFF_RXHOLD: rd_mux = format_q[7] ? 8'h00 : rx_data;
            `UIFC_OFF_MASK:   rd_mux = mask_q;
            `UIFC_OFF_STATUS: rd_mux = format_q == 8'hBF ? enh_q : status_word;
            `UIFC_OFF_FORMAT: rd_mux = format_q;
            `UIFC_OFF_LINE:   rd_mux = line_status;
            `UIFC_OFF_MODEM:  rd_mux = modem_status;
            `UIFC_OFF_ENH:    rd_mux = enh_q;
            default:          rd_mux = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            reg_rdata <= rd_mux;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // Mode 0: single-char semantics; mode 1: rx pin trigger based, tx pin inactive once 64 are queued
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            transmit_ready_pin_n <= 1'b1;
            receive_ready_pin_n  <= 1'b1;
        end else if (dma_q && qen_q) begin
            transmit_ready_pin_n <= tx_level >= 7'd64;
            receive_ready_pin_n  <= !(rx_at || tout_q);
        end else begin
            transmit_ready_pin_n <= tx_level != 0;
            receive_ready_pin_n  <= rx_level == 0;
        end
    end

    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            queue_enable <= 1'b0;
            irq_pending  <= 1'b0;
        end else begin
            queue_enable <= qen_q;
            irq_pending  <= !status_word[0];
        end
    end

    // Stop length in half bits; the code 0 stands for four halves
    always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            word_len_sel   <= 2'h0;
            stop_half_bits <= 2'h2;
        end else begin
            word_len_sel <= format_q[1:0];
            if (!format_q[2])
                stop_half_bits <= 2'h2;
            else if (format_q[1:0] == 2'h0)
                stop_half_bits <= 2'h3;
            else
                stop_half_bits <= 2'h0;
        end
    end
endmodule

/* File: bench/uifc_ctrl_properties.sv */
`timescale 1ns/10ps
module uifc_ctrl_props (
    input logic       core_clk,
    input logic       rst_n,
    input logic [2:0] reg_addr,
    input logic [7:0] reg_wdata,
    input logic       reg_wr,
    input logic       reg_rd,
    input logic [7:0] reg_rdata,
    input logic       rx_queue_reset,
    input logic       tx_queue_reset,
    input logic       queue_enable,
    input logic [1:0] word_len_sel,
    input logic [1:0] stop_half_bits,
    input logic       thr_write_stb
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Word length 8 excludes the bank-switch format, so the write is known to land
    sequence qc_wr(b);
        reg_wr && reg_addr == 3'h2 && word_len_sel != 2'h3 && reg_wdata[0] == b;
    endsequence
    sequence fmt_wr;
        reg_wr && reg_addr == 3'h3;
    endsequence
    rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    rxrst_cause_a: assert property ($rose(rx_queue_reset) |->
        $past(reg_wr && reg_addr == 3'h2 && reg_wdata[1:0] == 2'h3))
        else $error("rx queue reset without enabled request");
    rxrst_pulse_a: assert property (rx_queue_reset |=> !rx_queue_reset)
        else $error("rx queue reset longer than one cycle");
    txrst_cause_a: assert property ($rose(tx_queue_reset) |->
        $past(reg_wr && reg_addr == 3'h2 && reg_wdata[2] && reg_wdata[0]))
        else $error("tx queue reset without enabled request");
    qen_on_a: assert property (qc_wr(1'b1) |=> ##1 queue_enable)
        else $error("queue enable not set");
    qen_off_a: assert property (qc_wr(1'b0) |=> ##1 !queue_enable)
        else $error("queue enable not cleared");
    wlen_set_a: assert property (fmt_wr |=> ##1 word_len_sel == $past(reg_wdata[1:0], 2))
        else $error("word length wrong");
    stop_set_a: assert property (fmt_wr |=> ##1 stop_half_bits ==
        (!$past(reg_wdata[2], 2) ? 2'h2 : ($past(reg_wdata[1:0], 2) == 2'h0 ? 2'h3 : 2'h0)))
        else $error("stop length wrong");
    fifo_bits_a: assert property (reg_rd && reg_addr == 3'h2 && word_len_sel != 2'h3 |=>
        reg_rdata[7:6] == {2{queue_enable}})
        else $error("status top bits differ from queue enable");
    thr_stb_a: assert property ($rose(thr_write_stb) |-> $past(reg_wr && reg_addr == 3'h0))
        else $error("holding write strobe without write");
endmodule
bind uifc_ctrl uifc_ctrl_props uifc_ctrl_props_inst (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rx_queue_reset(rx_queue_reset), .tx_queue_reset(tx_queue_reset),
    .queue_enable(queue_enable), .word_len_sel(word_len_sel),
    .stop_half_bits(stop_half_bits), .thr_write_stb(thr_write_stb));

/* File: bench/uifc_far_model.sv */
`timescale 1ns/10ps
module uifc_far_model (
    input  logic       core_clk,
    output logic [7:0] line_status,
    output logic [7:0] modem_status,
    output logic [7:0] rx_data,
    output logic [6:0] rx_level,
    output logic [6:0] tx_level,
    output logic       bit_tick,
    output logic       cts_pin,
    output logic       rts_out
);
    logic [2:0] div_q;
    assign rx_data = 8'h5A;
    assign cts_pin = 1'b0;
    assign rts_out = 1'b0;
    // Half full so the transmit source stays quiet
    assign tx_level = 7'h20;
    initial begin
        line_status = 8'h00;
        modem_status = 8'h00;
        rx_level = 7'h00;
        div_q = 3'h0;
        bit_tick = 1'b0;
    end
    always @(posedge core_clk) begin
        div_q <= div_q + 3'h1;
        bit_tick <= (div_q == 3'h7);
    end
    // Leaves time for the flag and the encoder behind it to settle
    task automatic set_src(input logic [7:0] ls, input logic [7:0] ms, input logic [6:0] rl);
        @(posedge core_clk);
        line_status <= ls;
        modem_status <= ms;
        rx_level <= rl;
        repeat (3) @(posedge core_clk);
    endtask
endmodule

/* File: bench/uifc_ctrl_test.sv */
`timescale 1ns/10ps
module uifc_ctrl_test;
    logic       core_clk, rst_n, reg_wr, reg_rd, bit_tick, cts_pin, rts_out;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, line_status, modem_status, rx_data;
    logic [6:0] rx_level, tx_level;
    logic       rx_qr, tx_qr, tx_pin_n, rx_pin_n, queue_enable, irq_pending, thr_stb;
    logic [1:0] word_len_sel, stop_half_bits;
    logic       xoff_seen = 1'b0;
    logic [6:0] lvl [4] = '{7'h08, 7'h10, 7'h38, 7'h3C};
    int         err_total, tests_run, cyc, k;
    uifc_far_model uifc_far_model_inst (.core_clk(core_clk), .line_status(line_status),
        .modem_status(modem_status), .rx_data(rx_data), .rx_level(rx_level),
        .tx_level(tx_level), .bit_tick(bit_tick), .cts_pin(cts_pin), .rts_out(rts_out));
    uifc_ctrl uifc_ctrl_inst (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .line_status(line_status), .modem_status(modem_status), .rx_data(rx_data),
        .rx_level(rx_level), .tx_level(tx_level), .rx_char_stb(1'b0), .bit_tick(bit_tick),
        .xoff_seen(xoff_seen), .xon_seen(1'b0), .special_seen(1'b0), .cts_pin(cts_pin),
        .rts_out(rts_out), .rx_queue_reset(rx_qr), .tx_queue_reset(tx_qr),
        .transmit_ready_pin_n(tx_pin_n), .receive_ready_pin_n(rx_pin_n),
        .queue_enable(queue_enable), .word_len_sel(word_len_sel),
        .stop_half_bits(stop_half_bits), .irq_pending(irq_pending), .thr_write_stb(thr_stb));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        @(negedge core_clk);
        check(reg_rdata, exp);
    endtask
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            conclude();
        end
    end
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        repeat (4) @(posedge core_clk);
        rst_n <= 1'b1;
        rd(3'h2, 8'h01);
        check({tx_pin_n, rx_pin_n, irq_pending, queue_enable, stop_half_bits, word_len_sel},
            8'hC8);
        for (k = 0; k < 8; k++) begin
            wr(3'h3, 8'(k));
            rd(3'h3, 8'(k));
            check({4'h0, word_len_sel, stop_half_bits},
                {4'h0, 2'(k), k < 4 ? 2'h2 : (k == 4 ? 2'h3 : 2'h0)});
        end
        wr(3'h3, 8'h02);
        wr(3'h2, 8'h01);
        rd(3'h2, 8'hC1);
        wr(3'h2, 8'h07);
        @(negedge core_clk);
        check(8'({rx_qr, tx_qr}), 8'h03);
        wr(3'h2, 8'h06);
        rd(3'h2, 8'h01);
        wr(3'h2, 8'h01);
        wr(3'h1, 8'h0C);
        uifc_far_model_inst.set_src(8'h02, 8'h01, 7'h00);
        rd(3'h2, 8'hC6);
        check(8'(irq_pending), 8'h01);
        uifc_far_model_inst.set_src(8'h00, 8'h01, 7'h00);
        rd(3'h2, 8'hC0);
        uifc_far_model_inst.set_src(8'h00, 8'h00, 7'h00);
        rd(3'h2, 8'hC1);
        wr(3'h1, 8'h00);
        uifc_far_model_inst.set_src(8'h02, 8'h01, 7'h00);
        rd(3'h2, 8'hC1);
        uifc_far_model_inst.set_src(8'h00, 8'h00, 7'h00);
        wr(3'h1, 8'h01);
        for (k = 0; k < 4; k++) begin
            wr(3'h2, {2'(k), 6'h01});
            uifc_far_model_inst.set_src(8'h00, 8'h00, lvl[k] - 7'h01);
            rd(3'h2, 8'hC1);
            uifc_far_model_inst.set_src(8'h00, 8'h00, lvl[k]);
            rd(3'h2, 8'hC4);
            check(8'({tx_pin_n, rx_pin_n}), 8'h02);
        end
        wr(3'h2, 8'hC9);
        uifc_far_model_inst.set_src(8'h00, 8'h00, 7'h3C);
        @(negedge core_clk);
        check(8'({tx_pin_n, rx_pin_n}), 8'h00);
        repeat (400) @(posedge core_clk);
        rd(3'h2, 8'hCC);
        rd(3'h0, 8'h5A);
        rd(3'h2, 8'hC4);
        wr(3'h7, 8'h10);
        wr(3'h1, 8'h20);
        xoff_seen <= 1'b1;
        @(posedge core_clk);
        xoff_seen <= 1'b0;
        rd(3'h2, 8'hD0);
        rd(3'h2, 8'hC1);
        uifc_far_model_inst.set_src(8'h00, 8'h00, 7'h00);
        rd(3'h4, 8'h00);
        wr(3'h0, 8'h55);
        @(negedge core_clk);
        check(8'(thr_stb), 8'h01);
        conclude();
    end
endmodule
